// ==== rtl/vps_clk_detect.sv ====
`timescale 1ns/100ps
`default_nettype none
module vps_clk_detect
    import vps_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic enable,
    input wire logic link_clk,
    output logic valid
);
    logic sync_a;
    logic sync_b;
    logic sync_c;
    logic [7:0] win;
    logic [3:0] edges;
    wire rise = sync_b & ~sync_c;
    wire win_end = (win == 8'(DET_WINDOW_CYC - 1));
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sync_a <= 1'b0;
            sync_b <= 1'b0;
            sync_c <= 1'b0;
        end else begin
            sync_a <= link_clk;
            sync_b <= sync_a;
            sync_c <= sync_b;
        end
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            win <= 8'h00;
            edges <= 4'h0;
            valid <= 1'b0;
        end else if (!enable) begin
            win <= 8'h00;
            edges <= 4'h0;
            valid <= 1'b0;
        end else if (win_end) begin
            win <= 8'h00;
            edges <= 4'h0;
            valid <= (edges >= 4'(DET_MIN_EDGES));
        end else begin
            win <= win + 8'h01;
            if (rise && edges != 4'hF)
                edges <= edges + 4'h1;
        end
    end
endmodule
`default_nettype wire

// ==== rtl/vps_pkg.sv ====
package vps_pkg;
    // register address and bit layout
    localparam logic [7:0] STATUS_ADDR = 8'h01;
    localparam logic [7:0] CONTROL_ADDR = 8'h02;
    localparam logic [7:0] SELECT_ADDR = 8'h03;
    localparam logic [6:0] TARGET_ADDR_BASE = 7'h2C;
    // control register fields
    localparam int CTL_EDGE_LSB = 0;
    localparam int CTL_BUF_BIT = 2;
    localparam int CTL_PWRDN_BIT = 3;
    localparam int CTL_CDBYP_BIT = 4;
    localparam int CTL_AUTO_BIT = 5;
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [1:0] SELECT_RESET = 2'h0;
    // synchroniser idle levels: low-power pin, scl and sda high
    localparam logic [9:0] SYNC_RESET = 10'h046;
    localparam logic [1:0] EDGE_FASTEST = 2'h0;
    // clock detect: link clock 125 ns, valid within a window
    localparam int CLK_MHZ = 200;
    localparam int DET_WINDOW_NS = 1000;
    localparam int DET_WINDOW_CYC = DET_WINDOW_NS * CLK_MHZ / 1000;
    localparam int DET_MIN_EDGES = 4;
    typedef enum logic [1:0] {VPS_IDLE, VPS_CLKWAIT, VPS_ACTIVE} vps_state_t;
    typedef enum logic [2:0] {
        VPS_I_IDLE, VPS_I_ADDR, VPS_I_ACK, VPS_I_WR, VPS_I_RD
    } vps_i2c_t;
endpackage

// ==== rtl/vps_switch_ctrl.sv ====
// Function
// - selected port: clock terms, detect, repeater on
// - valid clock enables data terms, output
// - unselected ports off except hotplug, which follows sense
// - no valid clock: data terms off, output hi-z
// - select pin high gives register mode
// - select pin low gives pin mode
// - i2c side is target only
// - registers set edge, buffer, power, detect, auto, port
// - register mode irq on status changes
// - status read clears irq
// - pin mode port from select pins
// - pin mode power from low-power pin
// - pin mode fastest edge, buffer pin
// - pin mode irq follows valid clock
// - detect bypass only in register mode
// - four edge settings, fastest default
// - auto select only in register mode
// - hotplug outputs follow sense or sink
// - select pins decode to ports 0..3
// - low-power pin forces all off
`timescale 1ns/100ps
`default_nettype none
module vps_switch_ctrl
    import vps_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic ctrl_mode_select,
    input wire logic source_select_low,
    input wire logic source_select_high,
    input wire logic low_power_select_n,
    input wire logic buffer_level_select,
    input wire logic [3:0] source_power_sense,
    input wire logic sink_hotplug_in,
    input wire logic [3:0] link_clk,
    input wire logic target_addr_bit,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    output logic [3:0] clk_term_en,
    output logic [3:0] data_term_en,
    output logic [3:0] ddc_repeater_en,
    output logic [3:0] receiver_en,
    output logic output_enable,
    output logic [1:0] edge_rate,
    output logic buffer_level,
    output logic low_power,
    output logic [3:0] port_hotplug_out,
    output logic irq
);
    // --------------------------------------------------------------
    // input synchronisers
    // --------------------------------------------------------------
    logic [9:0] sy1;
    logic [9:0] sy2;
    wire [9:0] raw = {ctrl_mode_select, source_select_low,
        source_select_high, low_power_select_n, buffer_level_select,
        sink_hotplug_in, target_addr_bit, scl_in, sda_in, 1'b0};
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sy1 <= SYNC_RESET;
            sy2 <= SYNC_RESET;
        end else begin
            sy1 <= raw;
            sy2 <= sy1;
        end
    end
    logic [3:0] pw1;
    logic [3:0] pw2;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pw1 <= 4'h0;
            pw2 <= 4'h0;
        end else begin
            pw1 <= source_power_sense;
            pw2 <= pw1;
        end
    end
    wire reg_mode = sy2[9];
    wire s_low = sy2[8];
    wire s_high = sy2[7];
    wire low_pwr_n = sy2[6];
    wire buf_pin = sy2[5];
    wire sink_plug = sy2[4];
    wire addr_bit = sy2[3];
    wire scl = sy2[2];
    wire sda = sy2[1];

    // --------------------------------------------------------------
    // registers
    // --------------------------------------------------------------
    logic [7:0] control;
    logic [1:0] sel_reg;
    logic [1:0] cur_port;
    logic [3:0] valid;
    wire [1:0] pin_port = {s_high, s_low};
    wire auto_en = reg_mode & control[CTL_AUTO_BIT];
    wire cd_bypass = reg_mode & control[CTL_CDBYP_BIT];
    wire pwr_down = ~low_pwr_n |
        (reg_mode & control[CTL_PWRDN_BIT]);
    wire [1:0] next_edge = reg_mode ?
        control[CTL_EDGE_LSB+1:CTL_EDGE_LSB] : EDGE_FASTEST;
    wire next_buf = reg_mode ? control[CTL_BUF_BIT] : buf_pin;
    // automatic selection: lowest powered port when the current one drops
    wire [1:0] auto_port = pw2[0] ? 2'h0 : pw2[1] ? 2'h1 :
        pw2[2] ? 2'h2 : pw2[3] ? 2'h3 : cur_port;
    wire [1:0] next_port = !reg_mode ? pin_port :
        (auto_en && !pw2[cur_port]) ? auto_port :
        auto_en ? cur_port : sel_reg;
    wire sel_valid = valid[cur_port] | cd_bypass;
    wire [7:0] status = {pw2, cur_port, 1'b0, valid[cur_port]};

    // --------------------------------------------------------------
    // port sequencing
    // --------------------------------------------------------------
    wire [3:0] onehot = 4'h1 << cur_port;
    wire [3:0] sel_mask = pwr_down ? 4'h0 : onehot;
    wire [3:0] next_dterm = sel_valid ? sel_mask : 4'h0;
    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_det
            vps_clk_detect u_det (
                .clk(clk),
                .rst(rst),
                .enable(sel_mask[g]),
                .link_clk(link_clk[g]),
                .valid(valid[g])
            );
        end
    endgenerate
    wire [3:0] next_hotplug;
    assign next_hotplug = (onehot & {4{sink_plug}}) | (~onehot & pw2);
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cur_port <= SELECT_RESET;
            clk_term_en <= 4'h0;
            ddc_repeater_en <= 4'h0;
            receiver_en <= 4'h0;
            data_term_en <= 4'h0;
            output_enable <= 1'b0;
            edge_rate <= EDGE_FASTEST;
            buffer_level <= 1'b0;
            low_power <= 1'b0;
            port_hotplug_out <= 4'h0;
        end else begin
            cur_port <= next_port;
            clk_term_en <= sel_mask;
            ddc_repeater_en <= sel_mask;
            receiver_en <= sel_mask;
            data_term_en <= next_dterm;
            output_enable <= |next_dterm;
            edge_rate <= next_edge;
            buffer_level <= next_buf;
            low_power <= pwr_down;
            port_hotplug_out <= pwr_down ? 4'h0 : next_hotplug;
        end
    end

    // --------------------------------------------------------------
    // i2c target
    // --------------------------------------------------------------
    vps_i2c_t ist;
    logic scl_d;
    logic sda_d;
    logic [7:0] sh;
    logic [3:0] bitn;
    logic [7:0] ptr;
    logic rw;
    logic got_ptr;
    logic data_ack;
    logic stat_read;
    wire scl_rise = scl & ~scl_d;
    wire scl_fall = ~scl & scl_d;
    wire start_c = scl & scl_d & sda_d & ~sda;
    wire stop_c = scl & scl_d & ~sda_d & sda;
    wire [6:0] my_addr = {TARGET_ADDR_BASE[6:1], addr_bit};
    wire [7:0] rd_data = (ptr == STATUS_ADDR) ? status :
        (ptr == CONTROL_ADDR) ? control :
        (ptr == SELECT_ADDR) ? {6'h00, sel_reg} : 8'h00;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            scl_d <= 1'b1;
            sda_d <= 1'b1;
        end else begin
            scl_d <= scl;
            sda_d <= sda;
        end
    end
    // only ever pulls sda low to ack or send data
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ist <= VPS_I_IDLE;
            sh <= 8'h00;
            bitn <= 4'h0;
            ptr <= 8'h00;
            rw <= 1'b0;
            got_ptr <= 1'b0;
            data_ack <= 1'b0;
            sda_oe <= 1'b0;
            sda_out <= 1'b0;
            control <= CONTROL_RESET;
            sel_reg <= SELECT_RESET;
            stat_read <= 1'b0;
        end else begin
            stat_read <= 1'b0;
            if (start_c) begin
                ist <= VPS_I_ADDR;
                bitn <= 4'h0;
                sda_oe <= 1'b0;
                got_ptr <= 1'b0;
            end else if (stop_c) begin
                ist <= VPS_I_IDLE;
                sda_oe <= 1'b0;
            end else if (scl_rise) begin
                sh <= {sh[6:0], sda};
                bitn <= bitn + 4'h1;
            end else if (scl_fall) begin
                unique case (ist)
                    VPS_I_IDLE: ;
                    VPS_I_ADDR: if (bitn == 4'h8) begin
                        bitn <= 4'h0;
                        if (sh[7:1] == my_addr) begin
                            rw <= sh[0];
                            ist <= VPS_I_ACK;
                            sda_oe <= 1'b1;
                            data_ack <= 1'b0;
                        end else begin
                            ist <= VPS_I_IDLE;
                        end
                    end
                    VPS_I_ACK: begin
                        bitn <= 4'h0;
                        if (rw) begin
                            ist <= VPS_I_RD;
                            sh <= rd_data;
                            sda_oe <= ~rd_data[7];
                            if (ptr == STATUS_ADDR)
                                stat_read <= 1'b1;
                            ptr <= ptr + 8'h01;
                        end else begin
                            ist <= VPS_I_WR;
                            sda_oe <= 1'b0;
                        end
                    end
                    VPS_I_WR: if (bitn == 4'h8) begin
                        bitn <= 4'h0;
                        ist <= VPS_I_ACK;
                        sda_oe <= 1'b1;
                        if (!got_ptr) begin
                            ptr <= sh;
                            got_ptr <= 1'b1;
                        end else begin
                            // status is never written
                            if (ptr == CONTROL_ADDR && reg_mode)
                                control <= sh;
                            if (ptr == SELECT_ADDR && reg_mode)
                                sel_reg <= sh[1:0];
                            ptr <= ptr + 8'h01;
                        end
                    end
                    VPS_I_RD: begin
                        if (bitn == 4'h8) begin
                            bitn <= 4'h0;
                            sda_oe <= 1'b0;
                            ist <= VPS_I_IDLE;
                        end else begin
                            // sh already advanced on the rising edge
                            sda_oe <= ~sh[7];
                        end
                    end
                    default: ist <= VPS_I_IDLE;
                endcase
            end
        end
    end

    // --------------------------------------------------------------
    // interrupt
    // --------------------------------------------------------------
    logic [7:0] status_d;
    wire change = (status_d != status);
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            status_d <= 8'h00;
            irq <= 1'b0;
        end else begin
            status_d <= status;
            if (!reg_mode)
                irq <= valid[cur_port];
            else if (change)
                irq <= 1'b1;
            else if (stat_read)
                irq <= 1'b0;
        end
    end

    chk_irq_clear: assert property (@(posedge clk) disable iff (rst)
        reg_mode && $past(reg_mode) && stat_read && !change |=> !irq)
        else $error("irq not cleared by status read");
    chk_unsel_off: assert property (@(posedge clk) disable iff (rst)
        (clk_term_en & ~(4'h1 << $past(cur_port))) == 4'h0)
        else $error("unselected port enabled");
    chk_out_valid: assert property (@(posedge clk) disable iff (rst)
        output_enable |-> $past(sel_valid) && !$past(pwr_down))
        else $error("output on without valid clock");
    chk_low_power: assert property (@(posedge clk) disable iff (rst)
        !low_pwr_n |=> low_power && clk_term_en == 4'h0)
        else $error("low power not forced");
    chk_pin_edge: assert property (@(posedge clk) disable iff (rst)
        !reg_mode |=> edge_rate == EDGE_FASTEST)
        else $error("pin mode edge not fastest");
    chk_pin_irq: assert property (@(posedge clk) disable iff (rst)
        !reg_mode |=> irq == $past(valid[cur_port]))
        else $error("pin mode irq wrong");
    chk_irq_set: assert property (@(posedge clk) disable iff (rst)
        reg_mode && change |=> irq)
        else $error("irq missed change");
    chk_pin_port: assert property (@(posedge clk) disable iff (rst)
        !reg_mode |=> cur_port == $past(pin_port))
        else $error("pin port not taken");
    chk_no_bypass: assert property (@(posedge clk) disable iff (rst)
        !reg_mode && !valid[cur_port] |=> data_term_en == 4'h0)
        else $error("bypass outside register mode");
endmodule
`default_nettype wire

// ==== tb/vps_source_model.sv ====
`timescale 1ns/100ps
`default_nettype none
// ------------------------------------------
// source side: one link clock per port
// ------------------------------------------
module vps_source_model (
    input wire logic [3:0] run,
    output logic [3:0] link_clk
);
    logic ref_clk = 1'b0;
    // free of the core clock phase; stands low while a source is off
    initial begin
        #3.3;
        forever #62.5 ref_clk = ~ref_clk;
    end
    assign link_clk = run & {4{ref_clk}};
endmodule
`default_nettype wire

// ==== tb/vps_switch_ctrl_tb.sv ====
`timescale 1ns/100ps
`default_nettype none
module vps_switch_ctrl_tb import vps_pkg::*;;
    localparam logic [6:0] TGT = {TARGET_ADDR_BASE[6:1], 1'b0};
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic ctrl_mode_select = 1'b0;
    logic source_select_low = 1'b0;
    logic source_select_high = 1'b0;
    logic low_power_select_n = 1'b1;
    logic buffer_level_select = 1'b0;
    logic [3:0] source_power_sense = 4'hA;
    logic sink_hotplug_in = 1'b1;
    logic [3:0] run = 4'h0;
    logic target_addr_bit = 1'b0;
    logic scl_in = 1'b1;
    logic m_sda = 1'b1;
    wire sda_in;
    logic [3:0] link_clk, clk_term_en, data_term_en;
    logic [3:0] ddc_repeater_en, receiver_en, port_hotplug_out;
    logic sda_oe, sda_out, output_enable, buffer_level, low_power, irq;
    logic [1:0] edge_rate;
    logic [7:0] rd;
    int miscompares = 0;
    int tests_run = 0;

    always #2.5 clk = ~clk;
    // open-drain data line with pull-up
    assign sda_in = sda_oe ? sda_out : m_sda;

    vps_source_model src (.run, .link_clk);
    vps_switch_ctrl uut (.clk, .rst, .ctrl_mode_select, .source_select_low,
        .source_select_high, .low_power_select_n, .buffer_level_select,
        .source_power_sense, .sink_hotplug_in, .link_clk, .target_addr_bit,
        .scl_in, .sda_in, .sda_out, .sda_oe, .clk_term_en, .data_term_en,
        .ddc_repeater_en, .receiver_en, .output_enable, .edge_rate,
        .buffer_level, .low_power, .port_hotplug_out, .irq);

    // ------------------------------------------
    // checking and closing
    // ------------------------------------------
    task automatic close_out();
        if (miscompares == 0 && tests_run > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [7:0] e, logic [7:0] g);
        tests_run++;
        if (g !== e) begin
            $display("[ERR] %s expected %h seen %h", nm, e, g);
            miscompares++;
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wait_oe(input logic want);
        int n;
        n = 0;
        while (output_enable !== want && n < 600) begin
            tick(1);
            n++;
        end
        chk("output_enable", 8'(want), 8'(output_enable));
        if (output_enable !== want)
            close_out();
    endtask

    // ------------------------------------------
    // local two-wire target access
    // ------------------------------------------
    task automatic bit_w(input logic b);
        m_sda = b;
        tick(8);
        scl_in = 1'b1;
        tick(16);
        scl_in = 1'b0;
        tick(8);
    endtask
    task automatic bit_r(output logic b);
        m_sda = 1'b1;
        tick(8);
        scl_in = 1'b1;
        tick(8);
        b = sda_in;
        tick(8);
        scl_in = 1'b0;
        tick(8);
    endtask
    task automatic start_c();
        m_sda = 1'b1;
        scl_in = 1'b1;
        tick(8);
        m_sda = 1'b0;
        tick(8);
        scl_in = 1'b0;
        tick(8);
    endtask
    task automatic stop_c();
        m_sda = 1'b0;
        tick(8);
        scl_in = 1'b1;
        tick(8);
        m_sda = 1'b1;
        tick(8);
    endtask
    task automatic byte_w(input logic [7:0] d);
        logic a;
        for (int i = 7; i >= 0; i--)
            bit_w(d[i]);
        bit_r(a);
        chk("ack", 8'h00, 8'(a));
    endtask
    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        start_c();
        byte_w({TGT, 1'b0});
        byte_w(a);
        byte_w(d);
        stop_c();
        tick(6);
    endtask
    task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
        start_c();
        byte_w({TGT, 1'b0});
        byte_w(a);
        stop_c();
        start_c();
        byte_w({TGT, 1'b1});
        for (int i = 7; i >= 0; i--)
            bit_r(d[i]);
        bit_w(1'b1);
        stop_c();
        tick(6);
    endtask

    // ------------------------------------------
    // scenarios
    // ------------------------------------------
    initial begin
        logic [3:0] oh;
        tick(5);
        chk("rst_oe", 8'h00, 8'(output_enable));
        rst = 1'b0;
        tick(3);
        for (int p = 0; p < 4; p++) begin
            oh = 4'h1 << p;
            {source_select_high, source_select_low} = p[1:0];
            buffer_level_select = p[0];
            tick(6);
            chk("clk_term_en", 8'(oh), 8'(clk_term_en));
            chk("ddc_rep", 8'(oh), 8'(ddc_repeater_en));
            chk("receiver_en", 8'(oh), 8'(receiver_en));
            chk("data_term_en", 8'h00, 8'(data_term_en));
            chk("edge_rate", 8'(EDGE_FASTEST), 8'(edge_rate));
            chk("buffer_level", 8'(p[0]), 8'(buffer_level));
            chk("irq_pin", 8'h00, 8'(irq));
            chk("hotplug", 8'((source_power_sense & ~oh) | oh),
                8'(port_hotplug_out));
        end
        run = 4'hA;
        wait_oe(1'b1);
        chk("data_term_en", 8'h08, 8'(data_term_en));
        chk("irq_pin", 8'h01, 8'(irq));
        run = 4'h2;
        wait_oe(1'b0);
        chk("data_term_en", 8'h00, 8'(data_term_en));
        low_power_select_n = 1'b0;
        tick(6);
        chk("low_power", 8'h01, 8'(low_power));
        chk("clk_term_en", 8'h00, 8'(clk_term_en));
        chk("hotplug", 8'h00, 8'(port_hotplug_out));
        low_power_select_n = 1'b1;
        ctrl_mode_select = 1'b1;
        tick(6);
        reg_wr(SELECT_ADDR, 8'h02);
        chk("clk_term_en", 8'h04, 8'(clk_term_en));
        reg_rd(STATUS_ADDR, rd);
        chk("status", 8'hA8, rd);
        chk("irq_reg", 8'h00, 8'(irq));
        source_power_sense = 4'h3;
        tick(6);
        chk("irq_reg", 8'h01, 8'(irq));
        chk("hotplug", 8'h07, 8'(port_hotplug_out));
        reg_wr(STATUS_ADDR, 8'hFF);
        reg_rd(STATUS_ADDR, rd);
        chk("status", 8'h38, rd);
        chk("irq_reg", 8'h00, 8'(irq));
        reg_rd(8'h10, rd);
        chk("unmapped", 8'h00, rd);
        reg_wr(CONTROL_ADDR, 8'h0B);
        chk("edge_rate", 8'h03, 8'(edge_rate));
        chk("low_power", 8'h01, 8'(low_power));
        reg_wr(CONTROL_ADDR, 8'h17);
        chk("data_term_en", 8'h04, 8'(data_term_en));
        chk("output_enable", 8'h01, 8'(output_enable));
        chk("buffer_level", 8'h01, 8'(buffer_level));
        reg_wr(CONTROL_ADDR, 8'h33);
        chk("auto_port", 8'h01, 8'(clk_term_en));
        chk("data_term_en", 8'h01, 8'(data_term_en));
        ctrl_mode_select = 1'b0;
        tick(8);
        chk("edge_rate", 8'(EDGE_FASTEST), 8'(edge_rate));
        chk("clk_term_en", 8'h08, 8'(clk_term_en));
        chk("output_enable", 8'h00, 8'(output_enable));
        close_out();
    end
endmodule
`default_nettype wire
